/* File: design/cidx_pkg.sv */
package cidx_pkg;
    // instruction word and field widths
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int TARGET_W = 11;
    localparam int PC_W = 13;
    localparam int DEST_BIT = 7;
    localparam int LATCH_LO = 3;
    localparam int LATCH_HI = 4;

    // opcode patterns (top six bits for file and literal ops, top seven for the accumulator store, top three for the jump)
    localparam logic [5:0] OP_DEC_FILE = 6'h03;
    localparam logic [5:0] OP_DEC_SKIP = 6'h07;
    localparam logic [5:0] OP_INC_FILE = 6'h0A;
    localparam logic [5:0] OP_INC_SKIP = 6'h0F;
    localparam logic [5:0] OP_OR_FILE = 6'h04;
    localparam logic [5:0] OP_MOVE_FILE = 6'h08;
    localparam logic [6:0] OP_MOVE_ACC = 7'h01;
    localparam logic [5:0] OP_OR_LIT = 6'h38;
    localparam logic [2:0] OP_JUMP = 3'h5;

    // reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

    typedef enum logic [1:0] {
        CIDX_Q1 = 2'b00,
        CIDX_Q2 = 2'b01,
        CIDX_Q3 = 2'b10,
        CIDX_Q4 = 2'b11
    } cidx_phase_t;

    typedef enum logic [3:0] {
        CIDX_OP_NONE = 4'h0,
        CIDX_OP_DEC = 4'h1,
        CIDX_OP_DECSZ = 4'h2,
        CIDX_OP_INC = 4'h3,
        CIDX_OP_INCSZ = 4'h4,
        CIDX_OP_ORF = 4'h5,
        CIDX_OP_ORL = 4'h6,
        CIDX_OP_MOVE_FILE = 4'h7,
        CIDX_OP_MOVE_ACC_TO_FILE = 4'h8,
        CIDX_OP_JUMP = 4'h9
    } cidx_op_t;
endpackage

/* File: design/cidx_decode.sv */
`timescale 1ns/1ps
module cidx_decode
    import cidx_pkg::*;
(
    input wire logic [cidx_pkg::INSTR_W-1:0] instr,
    output cidx_pkg::cidx_op_t op
);
    // unsupported encodings decode to none and execute as a no-operation
    always_comb begin
        if (instr[13:8] == OP_DEC_FILE) begin
            op = CIDX_OP_DEC;
        end else if (instr[13:8] == OP_DEC_SKIP) begin
            op = CIDX_OP_DECSZ;
        end else if (instr[13:8] == OP_INC_FILE) begin
            op = CIDX_OP_INC;
        end else if (instr[13:8] == OP_INC_SKIP) begin
            op = CIDX_OP_INCSZ;
        end else if (instr[13:8] == OP_OR_LIT) begin
            op = CIDX_OP_ORL;
        end else if (instr[13:8] == OP_OR_FILE) begin
            op = CIDX_OP_ORF;
        end else if (instr[13:8] == OP_MOVE_FILE) begin
            op = CIDX_OP_MOVE_FILE;
        end else if (instr[13:7] == OP_MOVE_ACC) begin
            op = CIDX_OP_MOVE_ACC_TO_FILE;
        end else if (instr[13:11] == OP_JUMP) begin
            op = CIDX_OP_JUMP;
        end else begin
            op = CIDX_OP_NONE;
        end
    end
endmodule

/* File: design/cidx_core.sv */
`timescale 1ns/1ps
// Operation
// - decrement file into accumulator or file
// - decrement, skip next when zero, flags kept
// - jump loads literal plus latch bits 4:3
// - jump takes two cycles, flags kept
// - increment file, update zero flag
// - increment, skip next when zero, flags kept
// - or literal into accumulator, update zero
// - or accumulator with file, update zero
// - move file to destination, update zero
// - store accumulator to file, one cycle
// - four phases: decode, read, process, write
// - skipped cycle only advances the PC
// - fields: 7-bit file, 8-bit literal, 11-bit target
module cidx_core
    import cidx_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [cidx_pkg::INSTR_W-1:0] instr_data,
    input wire logic [cidx_pkg::DATA_W-1:0] file_rdata,
    input wire logic [cidx_pkg::DATA_W-1:0] pc_latch,
    output logic [cidx_pkg::PC_W-1:0] pc,
    output logic [cidx_pkg::FADDR_W-1:0] file_addr,
    output logic file_rd,
    output logic file_wr,
    output logic [cidx_pkg::DATA_W-1:0] file_wdata,
    output logic [cidx_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic [1:0] phase,
    output logic cycle_start
);
    import cidx_pkg::*;

    cidx_phase_t phase_reg;
    cidx_op_t op_dec;
    cidx_op_t op_reg;
    logic [INSTR_W-1:0] instr_reg;
    logic [DATA_W-1:0] operand_reg;
    logic [DATA_W-1:0] result_reg;
    logic [DATA_W-1:0] result_next;
    logic [PC_W-1:0] pc_reg;
    logic [DATA_W-1:0] acc_reg;
    logic zero_reg;
    logic null_cycle_reg;
    logic null_pending_reg;
    logic file_rd_reg;
    logic file_wr_reg;
    logic [DATA_W-1:0] file_wdata_reg;
    logic [FADDR_W-1:0] file_addr_reg;
    logic dest_file;
    logic writes_zero;
    logic second_cycle;
    logic cycle_start_reg;

    cidx_decode u_decode (
        .instr(instr_data),
        .op(op_dec)
    );

    // quarter-phase sequencer; every instruction cycle is four sys_clk edges
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase_reg <= CIDX_Q1;
        end else begin
            case (phase_reg)
                CIDX_Q1: phase_reg <= CIDX_Q2;
                CIDX_Q2: phase_reg <= CIDX_Q3;
                CIDX_Q3: phase_reg <= CIDX_Q4;
                CIDX_Q4: phase_reg <= CIDX_Q1;
                default: phase_reg <= CIDX_Q1;
            endcase
        end
    end

    // Q1 decode; a null cycle latches no instruction word, only the none op, so the fetched word is discarded
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op_reg <= CIDX_OP_NONE;
            instr_reg <= 14'h0000;
            null_cycle_reg <= 1'b0;
        end else if (phase_reg == CIDX_Q1) begin
            if (null_pending_reg) begin
                op_reg <= CIDX_OP_NONE;
                null_cycle_reg <= 1'b1;
            end else begin
                op_reg <= op_dec;
                instr_reg <= instr_data;
                null_cycle_reg <= 1'b0;
            end
        end
    end

    assign dest_file = instr_reg[DEST_BIT];
    assign file_addr = file_addr_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            file_addr_reg <= 7'h00;
        end else if (phase_reg == CIDX_Q1) begin
            file_addr_reg <= instr_data[FADDR_W-1:0];
        end
    end

    // Q2 operand read; reading the file only where the op needs it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            file_rd_reg <= 1'b0;
        end else begin
            file_rd_reg <= (phase_reg == CIDX_Q1) && !null_pending_reg &&
                (op_dec inside {CIDX_OP_DEC, CIDX_OP_DECSZ, CIDX_OP_INC,
                 CIDX_OP_INCSZ, CIDX_OP_ORF, CIDX_OP_MOVE_FILE});
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            operand_reg <= 8'h00;
        end else if (phase_reg == CIDX_Q2) begin
            if (op_reg == CIDX_OP_ORL) begin
                operand_reg <= instr_reg[DATA_W-1:0];
            end else begin
                operand_reg <= file_rdata;
            end
        end
    end

    // Q3 data processing
    always_comb begin
        case (op_reg)
            CIDX_OP_DEC: result_next = operand_reg - 8'h01;
            CIDX_OP_DECSZ: result_next = operand_reg - 8'h01;
            CIDX_OP_INC: result_next = operand_reg + 8'h01;
            CIDX_OP_INCSZ: result_next = operand_reg + 8'h01;
            CIDX_OP_ORF: result_next = acc_reg | operand_reg;
            CIDX_OP_ORL: result_next = acc_reg | operand_reg;
            CIDX_OP_MOVE_FILE: result_next = operand_reg;
            CIDX_OP_MOVE_ACC_TO_FILE: result_next = acc_reg;
            default: result_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            result_reg <= 8'h00;
        end else if (phase_reg == CIDX_Q3) begin
            result_reg <= result_next;
        end
    end

    // skip-capable ops leave the flag alone, as do the store and the jump
    assign writes_zero = op_reg inside {CIDX_OP_DEC, CIDX_OP_INC, CIDX_OP_ORF,
        CIDX_OP_ORL, CIDX_OP_MOVE_FILE};

    // Q4 write-back
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_reg <= ACC_RESET;
        end else if (phase_reg == CIDX_Q4) begin
            if (op_reg == CIDX_OP_ORL) begin
                acc_reg <= result_reg;
            end else if ((op_reg inside {CIDX_OP_DEC, CIDX_OP_DECSZ, CIDX_OP_INC,
                          CIDX_OP_INCSZ, CIDX_OP_ORF, CIDX_OP_MOVE_FILE}) && !dest_file) begin
                acc_reg <= result_reg;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            zero_reg <= 1'b0;
        end else if (phase_reg == CIDX_Q4 && writes_zero) begin
            zero_reg <= (result_reg == 8'h00);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            file_wr_reg <= 1'b0;
            file_wdata_reg <= 8'h00;
        end else if (phase_reg == CIDX_Q3) begin
            // strobe is asserted during Q4 only
            file_wr_reg <= (op_reg == CIDX_OP_MOVE_ACC_TO_FILE) ||
                ((op_reg inside {CIDX_OP_DEC, CIDX_OP_DECSZ, CIDX_OP_INC,
                  CIDX_OP_INCSZ, CIDX_OP_ORF, CIDX_OP_MOVE_FILE}) && dest_file);
            file_wdata_reg <= result_next;
        end else begin
            file_wr_reg <= 1'b0;
        end
    end

    // skip request: a zero result turns the next cycle into a null cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            null_pending_reg <= 1'b0;
        end else if (phase_reg == CIDX_Q4) begin
            null_pending_reg <= ((op_reg == CIDX_OP_DECSZ || op_reg == CIDX_OP_INCSZ)
                && result_reg == 8'h00) || (op_reg == CIDX_OP_JUMP);
        end else if (phase_reg == CIDX_Q1) begin
            null_pending_reg <= 1'b0;
        end
    end

    // second cycle of jump writes PC; a skip cycle just advances past the dropped word
    assign second_cycle = null_cycle_reg && (instr_reg[13:11] == OP_JUMP);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_reg <= PC_RESET;
        end else if (phase_reg == CIDX_Q4) begin
            if (second_cycle) begin
                pc_reg <= {pc_latch[LATCH_HI:LATCH_LO],
                    instr_reg[TARGET_W-1:0]};
            end else if (op_reg == CIDX_OP_JUMP) begin
                pc_reg <= pc_reg;
            end else begin
                pc_reg <= pc_reg + 13'h0001;
            end
        end
    end

    assign pc = pc_reg;
    assign acc = acc_reg;
    assign zero_flag = zero_reg;
    assign phase = phase_reg;
    assign file_rd = file_rd_reg;
    assign file_wr = file_wr_reg;
    assign file_wdata = file_wdata_reg;
    // registered copy of the Q4 decode, high during Q1, so the output leaves a flip-flop
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cycle_start_reg <= 1'b1;
        end else begin
            cycle_start_reg <= (phase_reg == CIDX_Q4);
        end
    end

    assign cycle_start = cycle_start_reg;
endmodule

/* File: verif/cidx_core_asserts.sv */
`timescale 1ns/1ps
module cidx_core_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [cidx_pkg::INSTR_W-1:0] instr_data,
    input wire logic [cidx_pkg::DATA_W-1:0] file_rdata,
    input wire logic [cidx_pkg::DATA_W-1:0] pc_latch,
    input wire logic [cidx_pkg::PC_W-1:0] pc,
    input wire logic [cidx_pkg::FADDR_W-1:0] file_addr,
    input wire logic file_rd,
    input wire logic file_wr,
    input wire logic [cidx_pkg::DATA_W-1:0] file_wdata,
    input wire logic [cidx_pkg::DATA_W-1:0] acc,
    input wire logic zero_flag,
    input wire logic [1:0] phase,
    input wire logic cycle_start
);
    import cidx_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    property p_phase_step;
        !$past(rst) |-> $past(phase) + 2'd1 == phase;
    endproperty
    a_phase_step: assert property (p_phase_step)
        else $error("phase did not step");
    property p_read_q2;
        file_rd |-> phase == 2'd1 && file_addr == $past(instr_data[FADDR_W-1:0]);
    endproperty
    a_read_q2: assert property (p_read_q2)
        else $error("file read out of place");
    property p_write_q4;
        file_wr |-> phase == 2'd3 ##1 !file_wr;
    endproperty
    a_write_q4: assert property (p_write_q4)
        else $error("file write out of place");
    property p_store_acc;
        file_wr && instr_data[13:7] == OP_MOVE_ACC |-> file_wdata == acc;
    endproperty
    a_store_acc: assert property (p_store_acc)
        else $error("stored data is not acc");
    property p_acc_hold;
        !$past(rst) && $changed(acc) |-> $past(phase) == 2'h3;
    endproperty
    a_acc_hold: assert property (p_acc_hold)
        else $error("acc changed outside Q4");
    property p_pc_hold;
        !$past(rst) && $changed(pc) |-> $past(phase) == 2'h3;
    endproperty
    a_pc_hold: assert property (p_pc_hold)
        else $error("pc changed outside Q4");
    // skip and jump words leave the zero flag alone, and a jump also in its null cycle
    property p_flags_kept;
        phase == 2'd3 && (instr_data[13:8] == OP_DEC_SKIP || instr_data[13:8] == OP_INC_SKIP
            || instr_data[13:11] == OP_JUMP) |=> $stable(zero_flag);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("zero flag changed");
    property p_cycle_start;
        cycle_start == (phase == 2'd0);
    endproperty
    a_cycle_start: assert property (p_cycle_start)
        else $error("cycle start off Q1");
endmodule
bind cidx_core cidx_core_asserts u_chk (.*);

/* File: verif/cidx_mem_model.sv */
`timescale 1ns/1ps
module cidx_mem_model (
    input wire logic sys_clk,
    input wire logic [cidx_pkg::PC_W-1:0] pc,
    input wire logic [cidx_pkg::FADDR_W-1:0] file_addr,
    input wire logic file_rd,
    input wire logic file_wr,
    input wire logic [cidx_pkg::DATA_W-1:0] file_wdata,
    output logic [cidx_pkg::INSTR_W-1:0] instr_data,
    output logic [cidx_pkg::DATA_W-1:0] file_rdata
);
    import cidx_pkg::*;
    logic [INSTR_W-1:0] prog [64];
    logic [DATA_W-1:0] regs [128];
    initial begin
        instr_data = '0;
        file_rdata = '0;
        foreach (prog[i]) prog[i] = '0;
    end
    // no read pending: toggle the bus so stale data cannot pass as valid
    always @(negedge sys_clk) begin
        instr_data <= prog[pc[5:0]];
        file_rdata <= file_rd ? regs[file_addr] : ~file_rdata;
    end
    always @(posedge sys_clk) begin
        if (file_wr) begin
            regs[file_addr] <= file_wdata;
        end
    end
endmodule

/* File: verif/test_cidx_core.sv */
`timescale 1ns/1ps
module test_cidx_core;
    import cidx_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [INSTR_W-1:0] instr_data;
    logic [DATA_W-1:0] file_rdata, file_wdata, acc, pc_latch = '0;
    logic [PC_W-1:0] pc;
    logic [FADDR_W-1:0] file_addr;
    logic file_rd, file_wr, zero_flag, cycle_start;
    logic [1:0] phase;
    int num_errors = 0;
    int n_compared = 0;
    cidx_core dut (.*);
    cidx_mem_model mem (.*);
    always #12.5 sys_clk = ~sys_clk;
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task final_report;
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task cycles(input int n);
        repeat (4 * n) @(negedge sys_clk);
    endtask
    // restart so every scenario fetches from address zero
    task restart(input logic [13:0] w0, w1, w2, w3);
        @(negedge sys_clk);
        rst = 1'b1;
        mem.prog[0] = w0;
        mem.prog[1] = w1;
        mem.prog[2] = w2;
        mem.prog[3] = w3;
        @(negedge sys_clk);
        rst = 1'b0;
    endtask
    task t_inc_dec;
        mem.regs[5] = 8'hFF;
        restart(14'h0A05, 14'h0385, 14'h0000, 14'h0000);
        cycles(1);
        chk("acc", acc, 16'h0000);
        chk("zero", zero_flag, 16'h0001);
        cycles(1);
        chk("file", mem.regs[5], 16'h00FE);
        chk("zero", zero_flag, 16'h0000);
        chk("pc", pc, 16'h0002);
    endtask
    task t_skip;
        mem.regs[1] = 8'h01;
        mem.regs[2] = 8'h05;
        restart(14'h0781, 14'h0A01, 14'h0F02, 14'h0000);
        cycles(1);
        chk("file", mem.regs[1], 16'h0000);
        chk("pc", pc, 16'h0001);
        cycles(1);
        chk("pc", pc, 16'h0002);
        chk("acc", acc, 16'h0000);
        cycles(1);
        chk("acc", acc, 16'h0006);
        chk("zero", zero_flag, 16'h0000);
        chk("pc", pc, 16'h0003);
    endtask
    task t_or_move;
        mem.regs[3] = 8'h80;
        mem.regs[6] = 8'h00;
        restart(14'h3835, 14'h0483, 14'h0084, 14'h0886);
        cycles(1);
        chk("acc", acc, 16'h0035);
        cycles(3);
        chk("file", mem.regs[3], 16'h00B5);
        chk("file", mem.regs[4], 16'h0035);
        chk("zero", zero_flag, 16'h0001);
        chk("acc", acc, 16'h0035);
        chk("pc", pc, 16'h0004);
    endtask
    task t_jump;
        pc_latch = 8'hF7;
        restart(14'h2FFF, 14'h0A05, 14'h0000, 14'h0000);
        cycles(1);
        chk("pc", pc, 16'h0000);
        cycles(1);
        chk("pc", pc, 16'h17FF);
        chk("acc", acc, 16'h0000);
    endtask
    initial begin
        repeat (12) @(negedge sys_clk);
        t_inc_dec;
        t_skip;
        t_or_move;
        t_jump;
        final_report;
    end
    // the scenarios need under a hundred cycles; allow twenty times that
    initial begin
        #50000;
        num_errors++;
        final_report;
    end
endmodule
